/* File: shared/pic_pkg.sv */
// Constants and types for the priority interrupt controller
package pic_pkg;
  localparam int NUM_SRC = 9;
  // Source indices, index 0 is highest priority
  localparam int SRC_INTERVAL = 0;
  localparam int SRC_EXT0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TIMER = 3;
  localparam int SRC_EXT2 = 4;
  localparam int SRC_WDOG = 5;
  localparam int SRC_WATCH = 6;
  localparam int SRC_KEY = 7;
  localparam int SRC_BREAK = 8;
  localparam int NUM_EXT = 3;
  // Register offsets on the plain port
  localparam logic [3:0] OFS_ENABLE_LOW = 4'h0;
  localparam logic [3:0] OFS_ENABLE_HIGH = 4'h1;
  localparam logic [3:0] OFS_REQUEST_LOW = 4'h2;
  localparam logic [3:0] OFS_REQUEST_HIGH = 4'h3;
  localparam logic [3:0] OFS_EDGE_SELECT = 4'h4;
  localparam logic [3:0] OFS_STATUS_WORD = 4'h5;
  // Status word bit positions
  localparam int PSW_MASTER_BIT = 2;
  localparam int PSW_BREAK_BIT = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Acceptance takes 8 oscillator periods, here 8 sys_clk cycles
  localparam logic [2:0] ACCEPT_LAST = 3'h7;
  localparam logic [1:0] PUSH_COUNT = 2'h3;
  localparam logic [7:0] VECTOR_BASE = 8'he0;
  typedef enum logic [2:0] {
    PIC_IDLE, PIC_WAIT, PIC_ACCEPT, PIC_PUSH, PIC_FETCH, PIC_RUN
  } pic_state_t;
endpackage

/* File: verilog/pic_ctrl.sv */
// Priority interrupt controller with acceptance sequencer
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// R1: Eight maskable sources, each with request flag and enable flag.
// R2: Fixed priority: interval, ext0, ext1, timer, ext2, watchdog, watch, key.
// R3: External lines trigger on signal transitions, not levels.
// R4: External flags sit in high request register; cleared on vectoring.
// R5: Timer match sets the timer match flag.
// R6: Interval timer overflow sets the interval overflow flag.
// R7: Accept only when flag, enable and master enable all set; break bypasses.
// R8: Zero enable never accepted; master clear blocks all maskable.
// R9: Flags hold until accepted, reset, or cleared by write.
// R10: Acceptance starts after instruction ends and lasts 8 periods.
// R11: Acceptance clears master enable; break blocks further acceptance too.
// R12: Flag of accepted source cleared during acceptance.
// R13: Push return address and status word, stack pointer down three times.
// R14: Fetch entry from vector location, load it, then execute.
// R15: With master enable clear nothing is accepted, whatever priority; break is still accepted here.
// R16: Only program counter and status word saved by hardware.
// R17: Interrupt return ends service and resumes interrupted program.
// R18: Software break ranks below every other source.
// R19: Break shares table call zero vector; sets break flag in status.
// R20: Simultaneous requests resolved to the higher priority one.
// R21: Edge selection offers rising, falling or both edges.
// R22: Reset clears master enable, all enables and all flags.
module pic_ctrl
  import pic_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  input wire logic external_line_zero,
  input wire logic external_line_one,
  input wire logic external_line_two,
  input wire logic interval_overflow,
  input wire logic timer_match,
  input wire logic watchdog_source,
  input wire logic watch_clock_source,
  input wire logic keypad_source,
  input wire logic software_break,
  input wire logic instr_done,
  input wire logic interrupt_return,
  input wire logic set_master_enable_instr,
  input wire logic [15:0] return_pc,
  input wire logic [15:0] vector_data,
  output logic stack_push_q,
  output logic [7:0] stack_data_q,
  output logic [7:0] vector_addr_q,
  output logic vector_rd_q,
  output logic pc_load_q,
  output logic [15:0] pc_value_q,
  output logic accept_busy_q,
  output logic in_service_q
);
  import pic_pkg::*;

  pic_state_t state_q;
  logic [7:0] enable_reg_low_q;
  logic [7:0] enable_reg_high_q;
  logic [NUM_SRC-1:0] flag_q;
  logic [5:0] edge_select_q;
  logic [7:0] program_status_word_q;
  logic [NUM_EXT-1:0] ext_prev_q;
  logic [2:0] cycle_q;
  logic [1:0] push_q;
  logic [3:0] src_q;
  logic [7:0] saved_psw_q;
  logic [NUM_SRC-1:0] enable_vec;
  logic [NUM_SRC-1:0] set_vec;
  logic [NUM_SRC-1:0] wr_clr;
  logic [NUM_SRC-1:0] acc_clr;
  logic [NUM_SRC-1:0] pending;
  logic [NUM_EXT-1:0] ext_in;
  logic [NUM_EXT-1:0] ext_edge;
  logic [3:0] winner;
  logic any_pending;
  logic master_en;
  logic [23:0] push_bytes;
  logic [7:0] req_low_view;
  logic [7:0] req_high_view;

  assign master_en = program_status_word_q[PSW_MASTER_BIT];
  assign ext_in = {external_line_two, external_line_one, external_line_zero};
  // Enable layout: low reg holds interval..ext2 in bits 0..4, high reg the rest
  assign enable_vec = {1'b1, enable_reg_high_q[2:0], enable_reg_low_q[4:0]};
  // Timer-type and key flags in the low request byte, the three line flags in the high one
  assign req_low_view = {3'h0, flag_q[SRC_KEY], flag_q[SRC_WATCH], flag_q[SRC_WDOG],
    flag_q[SRC_TIMER], flag_q[SRC_INTERVAL]};
  assign req_high_view = {5'h0, flag_q[SRC_EXT2], flag_q[SRC_EXT1], flag_q[SRC_EXT0]}; // R4

  // Edge detection per external line
  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g++) begin : g_edge
      logic rise;
      logic fall;
      assign rise = ext_in[g] & ~ext_prev_q[g];
      assign fall = ~ext_in[g] & ext_prev_q[g];
      assign ext_edge[g] = (edge_select_q[2*g+1] & rise) | (edge_select_q[2*g] & fall); // R3 R21
    end
  endgenerate

  // Tracks the pins through reset too, so release brings no false edge
  always_ff @(posedge sys_clk) begin
    ext_prev_q <= ext_in;
  end

  always_comb begin
    set_vec = '0;
    set_vec[SRC_INTERVAL] = interval_overflow; // R6
    set_vec[SRC_EXT0] = ext_edge[0];
    set_vec[SRC_EXT1] = ext_edge[1];
    set_vec[SRC_TIMER] = timer_match; // R5
    set_vec[SRC_EXT2] = ext_edge[2];
    set_vec[SRC_WDOG] = watchdog_source;
    set_vec[SRC_WATCH] = watch_clock_source;
    set_vec[SRC_KEY] = keypad_source;
    set_vec[SRC_BREAK] = software_break & (state_q == PIC_IDLE);
  end

  // Maskable gating; break bypasses master and enable
  always_comb begin
    pending = flag_q & enable_vec & {1'b1, {(NUM_SRC-1){master_en}}}; // R7 R8 R15
  end

  // Lowest index wins; break is index 8, so it ranks last
  always_comb begin
    winner = 4'h0;
    any_pending = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        winner = 4'(i); // R2 R18 R20
        any_pending = 1'b1;
      end
    end
  end

  always_comb begin
    wr_clr = '0;
    if (reg_wr && reg_addr == OFS_REQUEST_LOW) begin
      {wr_clr[SRC_KEY], wr_clr[SRC_WATCH], wr_clr[SRC_WDOG], wr_clr[SRC_TIMER],
        wr_clr[SRC_INTERVAL]} = ~reg_wdata[4:0];
    end
    if (reg_wr && reg_addr == OFS_REQUEST_HIGH) begin
      {wr_clr[SRC_EXT2], wr_clr[SRC_EXT1], wr_clr[SRC_EXT0]} = ~reg_wdata[2:0]; // R4
    end
    acc_clr = '0;
    if (state_q == PIC_WAIT && instr_done) begin
      acc_clr[winner] = 1'b1; // R4 R12
    end
  end

  // Set beats clear, so no edge is lost
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flag_q <= '0; // R22
    end else begin
      flag_q <= (flag_q & ~wr_clr & ~acc_clr) | set_vec; // R9 R1
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      enable_reg_low_q <= RESET_BYTE; // R22
      enable_reg_high_q <= RESET_BYTE;
      edge_select_q <= '0;
    end else if (reg_wr) begin
      if (reg_addr == OFS_ENABLE_LOW) begin
        enable_reg_low_q <= reg_wdata;
      end
      if (reg_addr == OFS_ENABLE_HIGH) begin
        enable_reg_high_q <= reg_wdata;
      end
      if (reg_addr == OFS_EDGE_SELECT) begin
        edge_select_q <= reg_wdata[5:0];
      end
    end
  end

  // Status word: master enable and break flag are hardware-steered
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      program_status_word_q <= RESET_BYTE; // R22
    end else if (state_q == PIC_WAIT && instr_done) begin
      program_status_word_q[PSW_MASTER_BIT] <= 1'b0; // R11
      program_status_word_q[PSW_BREAK_BIT] <= (winner == 4'(SRC_BREAK)); // R19
    end else if (state_q == PIC_RUN && interrupt_return) begin
      program_status_word_q <= saved_psw_q; // R17
    end else if (set_master_enable_instr) begin
      program_status_word_q[PSW_MASTER_BIT] <= 1'b1;
    end else if (reg_wr && reg_addr == OFS_STATUS_WORD) begin
      program_status_word_q <= reg_wdata;
    end
  end

  // Acceptance sequencer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= PIC_IDLE;
      cycle_q <= '0;
      push_q <= '0;
      src_q <= '0;
      saved_psw_q <= RESET_BYTE;
    end else begin
      unique case (state_q)
        PIC_IDLE, PIC_RUN: begin
          if (state_q == PIC_RUN && interrupt_return) begin
            state_q <= PIC_IDLE; // R17
          end else if (any_pending) begin
            state_q <= PIC_WAIT;
          end
        end
        PIC_WAIT: begin
          if (!any_pending) begin
            state_q <= PIC_IDLE;
          end else if (instr_done) begin
            state_q <= PIC_ACCEPT; // R10
            src_q <= winner;
            cycle_q <= '0;
            saved_psw_q <= program_status_word_q; // R16
          end
        end
        PIC_ACCEPT: begin
          cycle_q <= cycle_q + 3'h1;
          if (cycle_q == ACCEPT_LAST - 3'(PUSH_COUNT) - 3'h1) begin
            state_q <= PIC_PUSH;
            push_q <= '0;
          end
        end
        PIC_PUSH: begin
          cycle_q <= cycle_q + 3'h1;
          push_q <= push_q + 2'h1;
          if (push_q == PUSH_COUNT - 2'h1) begin
            state_q <= PIC_FETCH; // R13
          end
        end
        PIC_FETCH: begin
          state_q <= PIC_RUN; // R14
        end
      endcase
    end
  end

  assign push_bytes = {return_pc[7:0], return_pc[15:8], saved_psw_q};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stack_push_q <= 1'b0;
      stack_data_q <= '0;
      vector_rd_q <= 1'b0;
      vector_addr_q <= '0;
      pc_load_q <= 1'b0;
      pc_value_q <= '0;
    end else begin
      stack_push_q <= (state_q == PIC_PUSH); // R13 R16
      stack_data_q <= push_bytes[8*push_q +: 8];
      vector_rd_q <= (state_q == PIC_PUSH) && (push_q == PUSH_COUNT - 2'h1);
      // Break uses the table call zero slot, the last vector
      vector_addr_q <= VECTOR_BASE + {3'h0, src_q, 1'b0}; // R14 R19
      pc_load_q <= (state_q == PIC_FETCH);
      pc_value_q <= vector_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      accept_busy_q <= 1'b0;
      in_service_q <= 1'b0;
    end else begin
      accept_busy_q <= (state_q == PIC_ACCEPT) || (state_q == PIC_PUSH) || (state_q == PIC_FETCH);
      in_service_q <= (state_q != PIC_IDLE) && (state_q != PIC_WAIT);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_ENABLE_LOW: reg_rdata_q <= enable_reg_low_q;
        OFS_ENABLE_HIGH: reg_rdata_q <= enable_reg_high_q;
        OFS_REQUEST_LOW: reg_rdata_q <= req_low_view;
        OFS_REQUEST_HIGH: reg_rdata_q <= req_high_view;
        OFS_EDGE_SELECT: reg_rdata_q <= {2'h0, edge_select_q};
        OFS_STATUS_WORD: reg_rdata_q <= program_status_word_q;
        default: reg_rdata_q <= '0;
      endcase
    end else begin
      reg_rdata_q <= '0;
    end
  end

  // Assertions
  a_master_cleared: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
    state_q == PIC_WAIT && instr_done |=> !program_status_word_q[PSW_MASTER_BIT])
    else $error("master enable not cleared on accept");
  a_no_masked_accept: assert property (@(posedge sys_clk) disable iff (!rst_n) // R15
    state_q == PIC_WAIT && instr_done && winner != 4'(SRC_BREAK) |-> master_en)
    else $error("accept with master enable clear");
  a_enable_gates: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
    state_q == PIC_WAIT && instr_done |-> enable_vec[winner] && flag_q[winner])
    else $error("disabled source accepted");
  a_flag_cleared: assert property (@(posedge sys_clk) disable iff (!rst_n) // R12
    state_q == PIC_WAIT && instr_done && !set_vec[winner] |=> !flag_q[src_q])
    else $error("accepted flag not cleared");
  // Four accept, three push and one fetch cycle, then the service routine runs
  a_accept_length: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
    state_q == PIC_WAIT && instr_done |=> ##8 state_q == PIC_RUN)
    else $error("acceptance not 8 cycles");
  a_three_pushes: assert property (@(posedge sys_clk) disable iff (!rst_n) // R13
    $rose(stack_push_q) |-> stack_push_q [*3] ##1 !stack_push_q)
    else $error("push count not three");
  a_top_priority: assert property (@(posedge sys_clk) disable iff (!rst_n) // R2
    pending[SRC_INTERVAL] |-> winner == 4'(SRC_INTERVAL))
    else $error("interval source not highest");
  a_flag_holds: assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
    flag_q[SRC_KEY] && !wr_clr[SRC_KEY] && !acc_clr[SRC_KEY] |=> flag_q[SRC_KEY])
    else $error("request flag dropped");
  a_timer_sets: assert property (@(posedge sys_clk) disable iff (!rst_n) // R5
    timer_match |=> flag_q[SRC_TIMER])
    else $error("timer match lost");
  a_interval_sets: assert property (@(posedge sys_clk) disable iff (!rst_n) // R6
    interval_overflow |=> flag_q[SRC_INTERVAL])
    else $error("interval overflow lost");
  a_edge_sets_ext0: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
    ext_edge[0] |=> flag_q[SRC_EXT0])
    else $error("line zero edge lost");
  a_edge_sets_ext1: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
    ext_edge[1] |=> flag_q[SRC_EXT1])
    else $error("line one edge lost");
  a_edge_sets_ext2: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
    ext_edge[2] |=> flag_q[SRC_EXT2])
    else $error("line two edge lost");
  a_write_clears: assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
    reg_wr && reg_addr == OFS_REQUEST_HIGH && !reg_wdata[0] && !ext_edge[0]
      |=> !flag_q[SRC_EXT0])
    else $error("request write did not clear");
  a_masked_stay_idle: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
    state_q == PIC_IDLE && !master_en && !flag_q[SRC_BREAK] |=> state_q == PIC_IDLE)
    else $error("masked request left idle");
  a_break_lowest: assert property (@(posedge sys_clk) disable iff (!rst_n) // R18
    pending[SRC_BREAK] && |pending[SRC_KEY:SRC_INTERVAL] |-> winner != 4'(SRC_BREAK))
    else $error("break ranked above a source");
  a_break_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n) // R19
    state_q == PIC_WAIT && instr_done && winner == 4'(SRC_BREAK)
      |=> program_status_word_q[PSW_BREAK_BIT])
    else $error("break flag not set");
  a_status_pushed_first: assert property (@(posedge sys_clk) disable iff (!rst_n) // R16
    $rose(stack_push_q) |-> stack_data_q == saved_psw_q)
    else $error("status word not pushed first");
  a_vector_then_load: assert property (@(posedge sys_clk) disable iff (!rst_n) // R14
    vector_rd_q |=> pc_load_q)
    else $error("entry address not loaded");
  a_busy_covers_push: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
    stack_push_q |-> accept_busy_q)
    else $error("push outside acceptance");
  a_return_restores: assert property (@(posedge sys_clk) disable iff (!rst_n) // R17
    state_q == PIC_RUN && interrupt_return
      |=> state_q == PIC_IDLE && program_status_word_q == $past(saved_psw_q))
    else $error("return did not restore status");
  a_reset_clears: assert property (@(posedge sys_clk) // R22
    !rst_n |=> flag_q == '0 && !master_en && enable_reg_low_q == RESET_BYTE
      && enable_reg_high_q == RESET_BYTE)
    else $error("reset left state behind");
  // Main scenarios
  c_break_taken: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == PIC_WAIT && instr_done && winner == 4'(SRC_BREAK));
  c_nested: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == PIC_RUN && set_master_enable_instr ##[1:50] state_q == PIC_WAIT);
  c_return: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == PIC_RUN && interrupt_return);
  c_two_pending: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == PIC_WAIT && instr_done && $countones(pending) > 1);
  c_line_taken: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == PIC_WAIT && instr_done && winner == 4'(SRC_EXT0));
endmodule // pic_ctrl

/* File: bench/pic_core_model.sv */
// Core-side model: instruction pacing, stack capture and vector table
`timescale 1ns/1ps
module pic_core_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic accept_busy_q,
  input wire logic stack_push_q,
  input wire logic [7:0] stack_data_q,
  input wire logic vector_rd_q,
  input wire logic [7:0] vector_addr_q,
  output logic instr_done,
  output logic [15:0] return_pc,
  output logic [15:0] vector_data
);
  logic [7:0] stk[$];
  logic [7:0] va_q;
  logic [15:0] held_q;
  logic hold_q;
  logic ph_q;
  assign return_pc = 16'h1234;
  // Table entry while read; after the hold cycle the bus shows garbage
  assign vector_data = vector_rd_q ? {8'h80, vector_addr_q} : (hold_q ? held_q : ~held_q);
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ph_q <= 1'b0;
      instr_done <= 1'b0;
      hold_q <= 1'b0;
      held_q <= 16'h0000;
      va_q <= 8'h00;
    end else begin
      ph_q <= ~ph_q;
      // Instructions end every other cycle, masked by accept_busy_q one cycle late
      instr_done <= run && ph_q && !accept_busy_q;
      hold_q <= vector_rd_q;
      if (vector_rd_q) begin
        held_q <= {8'h80, vector_addr_q};
        va_q <= vector_addr_q;
      end
      if (stack_push_q) stk.push_back(stack_data_q);
    end
  end
endmodule // pic_core_model

/* File: bench/tb_priority_interrupt_controller.sv */
// Self-checking bench for the priority interrupt controller
`timescale 1ns/1ps
module tb_priority_interrupt_controller;
  import pic_pkg::*;
  typedef struct {int idx; logic [7:0] lo; logic [7:0] hi; logic [7:0] vec;} pic_row_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [10:0] pls = 11'h000;
  logic [2:0] ext_lvl = 3'h0;
  logic run = 1'b0;
  logic instr_done, stack_push_q, vector_rd_q, pc_load_q, accept_busy_q, in_service_q;
  logic [7:0] reg_rdata_q, stack_data_q, vector_addr_q;
  logic [15:0] return_pc, vector_data, pc_value_q;
  int n_mismatch = 0;
  int num_checks = 0;
  pic_row_t rows[8] = '{'{0, 8'h01, 8'h00, 8'he0}, '{1, 8'h02, 8'h00, 8'he2},
    '{2, 8'h04, 8'h00, 8'he4}, '{3, 8'h08, 8'h00, 8'he6}, '{4, 8'h10, 8'h00, 8'he8},
    '{5, 8'h00, 8'h01, 8'hea}, '{6, 8'h00, 8'h02, 8'hec}, '{7, 8'h00, 8'h04, 8'hee}};
  pic_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .external_line_zero(ext_lvl[0]), .external_line_one(ext_lvl[1]),
    .external_line_two(ext_lvl[2]), .interval_overflow(pls[0]), .timer_match(pls[3]),
    .watchdog_source(pls[5]), .watch_clock_source(pls[6]), .keypad_source(pls[7]),
    .software_break(pls[8]), .instr_done(instr_done), .interrupt_return(pls[9]),
    .set_master_enable_instr(pls[10]), .return_pc(return_pc), .vector_data(vector_data),
    .stack_push_q(stack_push_q), .stack_data_q(stack_data_q), .vector_addr_q(vector_addr_q),
    .vector_rd_q(vector_rd_q), .pc_load_q(pc_load_q), .pc_value_q(pc_value_q),
    .accept_busy_q(accept_busy_q), .in_service_q(in_service_q));
  pic_core_model m (.sys_clk(sys_clk), .rst_n(rst_n), .run(run), .accept_busy_q(accept_busy_q),
    .stack_push_q(stack_push_q), .stack_data_q(stack_data_q), .vector_rd_q(vector_rd_q),
    .vector_addr_q(vector_addr_q), .instr_done(instr_done), .return_pc(return_pc),
    .vector_data(vector_data));
  always #2 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk({8'h00, reg_rdata_q}, {8'h00, e});
  endtask
  // External sources toggle their line, the rest get a one-cycle pulse
  task automatic fire(input int i);
    @(posedge sys_clk);
    if (i == 1 || i == 2 || i == 4) ext_lvl[i/2] <= ~ext_lvl[i/2];
    else pls[i] <= 1'b1;
    @(posedge sys_clk);
    pls <= 11'h000;
  endtask
  // Status byte 8'hff skips the saved status comparison
  task automatic svc(input logic [7:0] vec, input logic [7:0] sw);
    int k;
    k = 0;
    while (pc_load_q !== 1'b1 && k < 60) begin
      @(posedge sys_clk);
      #1 k++;
    end
    chk(pc_value_q, {8'h80, vec});
    chk({8'h00, m.va_q}, {8'h00, vec});
    chk(16'(m.stk.size()), 16'h0003);
    if (sw != 8'hff) chk({8'h00, m.stk[0]}, {8'h00, sw});
    chk({m.stk[1], m.stk[2]}, 16'h1234);
    chk({15'h0, in_service_q}, 16'h0001);
    chk({15'h0, accept_busy_q}, 16'h0001);
    m.stk.delete();
  endtask
  task automatic ret;
    fire(9);
    // Looked at before a queued request can be accepted again
    repeat (2) @(posedge sys_clk);
    #1 chk({15'h0, in_service_q}, 16'h0000);
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 6; a++) rd(4'(a), 8'h00);
    rd(4'hf, 8'h00);
    wr(OFS_EDGE_SELECT, 8'h3f);
    foreach (rows[i]) begin
      wr(OFS_ENABLE_LOW, rows[i].lo);
      wr(OFS_ENABLE_HIGH, rows[i].hi);
      fire(10);
      fire(rows[i].idx);
      run <= 1'b1;
      svc(rows[i].vec, 8'h04);
      rd(OFS_REQUEST_LOW, 8'h00);
      rd(OFS_REQUEST_HIGH, 8'h00);
      rd(OFS_STATUS_WORD, 8'h00);
      ret();
      run <= 1'b0;
    end
    // Two pending at once, higher wins, lower follows after return
    wr(OFS_ENABLE_LOW, 8'h02);
    wr(OFS_ENABLE_HIGH, 8'h04);
    fire(7);
    fire(1);
    run <= 1'b1;
    svc(8'he2, 8'h04);
    ret();
    svc(8'hee, 8'h04);
    ret();
    wr(OFS_STATUS_WORD, 8'h00);
    wr(OFS_ENABLE_LOW, 8'h01);
    fire(0);
    repeat (30) @(posedge sys_clk);
    #1 chk({15'h0, in_service_q}, 16'h0000);
    rd(OFS_REQUEST_LOW, 8'h01);
    fire(10);
    svc(8'he0, 8'h04);
    ret();
    wr(OFS_ENABLE_LOW, 8'h00);
    fire(3);
    repeat (30) @(posedge sys_clk);
    #1 chk({15'h0, in_service_q}, 16'h0000);
    rd(OFS_REQUEST_LOW, 8'h02);
    wr(OFS_REQUEST_LOW, 8'h00);
    rd(OFS_REQUEST_LOW, 8'h00);
    wr(OFS_EDGE_SELECT, 8'h00);
    ext_lvl[0] <= 1'b1;
    wr(OFS_REQUEST_HIGH, 8'h00);
    wr(OFS_EDGE_SELECT, {6'h00, EDGE_RISE});
    ext_lvl[0] <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd(OFS_REQUEST_HIGH, 8'h00);
    ext_lvl[0] <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(OFS_REQUEST_HIGH, 8'h01);
    wr(OFS_REQUEST_HIGH, 8'h00);
    wr(OFS_STATUS_WORD, 8'h00);
    fire(8);
    svc(8'hf0, 8'h00);
    rd(OFS_STATUS_WORD, 8'h10);
    ret();
    print_verdict();
  end
endmodule // tb_priority_interrupt_controller
